// File: sdtb_params.svh
/*
  Constants of the two-bank SDRAM command and timing model: pin layout,
  latencies and command spacing in clock cycles, refresh budget.
  Assumes a 100 MHz system clock shared by both ends.
*/
`ifndef SDTB_PARAMS_SVH
`define SDTB_PARAMS_SVH
`define SDTB_ADDR_W      12
`define SDTB_DQ_W        16
`define SDTB_ROW_W       11
`define SDTB_COL_W       10
`define SDTB_AP_BIT      10
`define SDTB_BS_BIT      11
`define SDTB_BURST_LEN   4
`define SDTB_CL          3
`define SDTB_T_RCD       3
`define SDTB_T_RC        10
`define SDTB_T_RAS       6
`define SDTB_T_RP        3
`define SDTB_T_RRD       2
`define SDTB_T_DPL       2
`define SDTB_T_DAL       5
`define SDTB_T_PQL       2
`define SDTB_T_MCD       2
`define SDTB_CLK_MHZ     100
`define SDTB_REF_COUNT   4096
`define SDTB_T_REF_MS    64
`define SDTB_REF_INT_CYC ((`SDTB_T_REF_MS * 1000 * `SDTB_CLK_MHZ) / `SDTB_REF_COUNT)
`define SDTB_POWERUP_US  100
`define SDTB_POWERUP_CYC (`SDTB_POWERUP_US * `SDTB_CLK_MHZ)
`endif

// File: sdtb_pkg.sv
/*
  Types shared by both ends: command encoding and controller states.
  Assumes sdtb_params.svh for widths.
*/
package sdtb_pkg;
  // Encoding is {chip select, row strobe, column strobe, write enable}
  typedef enum logic [3:0] {
    SDTB_MODE_LOAD = 4'h0,
    SDTB_REFRESH   = 4'h1,
    SDTB_CLOSE     = 4'h2,
    SDTB_OPEN      = 4'h3,
    SDTB_WRITE     = 4'h4,
    SDTB_READ      = 4'h5,
    SDTB_BURST_END = 4'h6,
    SDTB_NOP       = 4'h7,
    SDTB_DESELECT  = 4'h8
  } sdtb_cmd_t;

  typedef enum logic [3:0] {
    SDTB_S_POWERUP = 4'h0,
    SDTB_S_CLOSEALL = 4'h1,
    SDTB_S_MODE    = 4'h3,
    SDTB_S_IDLE    = 4'h2,
    SDTB_S_OPEN    = 4'h6,
    SDTB_S_COLUMN  = 4'h7,
    SDTB_S_WAIT    = 4'h5,
    SDTB_S_SELFREF = 4'h4
  } sdtb_state_t;
endpackage

// File: sdtb_if.sv
/*
  Pin bundle between the memory controller and the SDRAM device.
  Each end drives its own data lanes with enables; no shared wire.
*/
`timescale 1ns/1ps
`include "sdtb_params.svh"
interface sdtb_if;
  logic                     cke;
  logic                     cs_n;
  logic                     ras_n;
  logic                     cas_n;
  logic                     we_n;
  logic [`SDTB_ADDR_W-1:0]  addr;
  logic [1:0]               dqm;
  logic [`SDTB_DQ_W-1:0]    dq_ctl;
  logic                     dq_ctl_oe;
  logic [`SDTB_DQ_W-1:0]    dq_dev;
  logic [1:0]               dq_dev_oe;

  modport dev (input cke, cs_n, ras_n, cas_n, we_n, addr, dqm, dq_ctl, dq_ctl_oe,
               output dq_dev, dq_dev_oe);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, addr, dqm, dq_ctl, dq_ctl_oe,
               input dq_dev, dq_dev_oe);
endinterface

// File: sdtb_dev.sv
/*
  SDRAM device end: decodes commands each rising edge, keeps bank state,
  runs read and write bursts over its own array, refresh and self-refresh,
  and flags controller spacing faults.
  Assumes the controller shares clk_sys_in and drives the sdtb_if pins.
*/
`timescale 1ns/1ps
`include "sdtb_params.svh"
module sdtb_dev #(
  parameter int ROW_W     = `SDTB_ROW_W,
  parameter int COL_W     = `SDTB_COL_W,
  parameter int BURST_LEN = `SDTB_BURST_LEN
) (
  input  wire logic                    clk_sys_in,
  input  wire logic                    arst_n_in,
  sdtb_if.dev                          bus,
  output logic [`SDTB_ADDR_W-1:0]      mode_reg_out,
  output logic [1:0]                   bank_open_out,
  output logic                         burst_active_out,
  output logic                         refresh_busy_out,
  output logic                         self_refresh_out,
  output logic                         timing_fault_out
);
  localparam int BW    = $clog2(BURST_LEN + 1);
  localparam int IDX_W = 1 + ROW_W + COL_W;

  typedef struct packed {
    logic                          cke;
    logic [1:0]                    dqm;
    logic [`SDTB_ADDR_W-1:0]       mode;
    logic [1:0]                    open;
    logic [1:0][ROW_W-1:0]         row;
    logic                          bact;
    logic                          bwr;
    logic                          bbank;
    logic                          bap;
    logic [COL_W-1:0]              bcol;
    logic [BW-1:0]                 bleft;
    logic [2:0]                    apc;
    logic                          apb;
    logic                          p1v;
    logic [`SDTB_DQ_W-1:0]         p1d;
    logic                          p2v;
    logic [`SDTB_DQ_W-1:0]         p2d;
    logic [1:0]                    qoe;
    logic [`SDTB_DQ_W-1:0]         qd;
    logic [3:0]                    refc;
    logic                          self;
    logic [1:0][3:0]               sa;
    logic [1:0][3:0]               sp;
    logic [3:0]                    sx;
    logic [3:0]                    sm;
    logic                          fault;
  } sdtb_dev_st_t;

  sdtb_dev_st_t           q;
  sdtb_dev_st_t           d;
  sdtb_pkg::sdtb_cmd_t    rcmd;
  sdtb_pkg::sdtb_cmd_t    cmd;
  logic                   bsel;
  logic                   apin;
  logic                   idle;
  logic                   stop;
  logic                   iss_v;
  logic                   iss_wr;
  logic                   iss_bank;
  logic                   iss_ap;
  logic [COL_W-1:0]       iss_col;
  logic [BW-1:0]          iss_left;
  logic [IDX_W-1:0]       idx;
  logic                   mw_en;
  logic [1:0]             mw_be;
  logic [`SDTB_DQ_W-1:0]  mem [0:(1<<IDX_W)-1];

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction

  // True when fewer than n cycles have passed since the counted event
  function automatic logic too_soon(input logic [3:0] v, input int n);
    return (32'(v) + 1) < n;
  endfunction

  always_comb begin
    d = q;
    d.cke = bus.cke;
    d.dqm = bus.dqm;
    // Read pipe; mask sampled last edge gates the word driven now
    d.qoe = {2{q.p2v}} & ~q.dqm;
    d.qd = q.p2d;
    d.p2v = q.p1v;
    d.p2d = q.p1d;
    d.p1v = 1'b0;
    for (int b = 0; b < 2; b++) begin
      d.sa[b] = sat_inc(q.sa[b]);
      d.sp[b] = sat_inc(q.sp[b]);
    end
    d.sx = sat_inc(q.sx);
    d.sm = sat_inc(q.sm);
    if (q.refc != 4'h0) begin
      d.refc = q.refc - 4'h1;
    end
    if (q.apc != 3'h0) begin
      d.apc = q.apc - 3'h1;
      if (q.apc == 3'h1) begin
        d.open[q.apb] = 1'b0;
        d.sp[q.apb] = 4'h0;
      end
    end
    // Commands count only when clock enable was high the edge before
    if (!q.cke || bus.cs_n) begin
      rcmd = sdtb_pkg::SDTB_NOP;
    end else begin
      rcmd = sdtb_pkg::sdtb_cmd_t'({1'b0, bus.ras_n, bus.cas_n, bus.we_n});
    end
    // Busy shows for the whole refresh period, but its last count already admits the next command
    cmd = (q.self || q.refc > 4'h1) ? sdtb_pkg::SDTB_NOP : rcmd;
    if (rcmd != sdtb_pkg::SDTB_NOP && (q.self || q.refc > 4'h1)) begin
      d.fault = 1'b1;
    end
    if (rcmd != sdtb_pkg::SDTB_NOP && too_soon(q.sm, `SDTB_T_MCD)) begin
      d.fault = 1'b1;
    end
    bsel = bus.addr[`SDTB_BS_BIT];
    apin = bus.addr[`SDTB_AP_BIT];
    idle = (q.open == 2'b00) && (q.apc == 3'h0) && !q.bact;
    stop = 1'b0;
    iss_v = 1'b0;
    iss_wr = 1'b0;
    iss_bank = 1'b0;
    iss_ap = 1'b0;
    iss_col = '0;
    iss_left = '0;
    if (q.self && bus.cke) begin
      d.self = 1'b0;
      d.refc = 4'(`SDTB_T_RC);
    end
    case (cmd)
      sdtb_pkg::SDTB_MODE_LOAD: begin
        if (idle) begin
          d.mode = bus.addr;
          d.sm = 4'h0;
        end
      end
      sdtb_pkg::SDTB_REFRESH: begin
        if (idle) begin
          if (bus.cke) begin
            if (too_soon(q.sx, `SDTB_T_RC)) begin
              d.fault = 1'b1;
            end
            d.refc = 4'(`SDTB_T_RC);
            d.sx = 4'h0;
          end else begin
            d.self = 1'b1;
          end
        end
      end
      sdtb_pkg::SDTB_OPEN: begin
        if (too_soon(q.sa[bsel], `SDTB_T_RC) || too_soon(q.sp[bsel], `SDTB_T_RP)
            || too_soon(q.sa[!bsel], `SDTB_T_RRD)) begin
          d.fault = 1'b1;
        end
        d.open[bsel] = 1'b1;
        d.row[bsel] = bus.addr[ROW_W-1:0];
        d.sa[bsel] = 4'h0;
        d.sx = 4'h0;
      end
      sdtb_pkg::SDTB_CLOSE: begin
        stop = apin || (bsel == q.bbank);
        for (int b = 0; b < 2; b++) begin
          if (apin || bsel == 1'(b)) begin
            if (q.open[b] && too_soon(q.sa[b], `SDTB_T_RAS)) begin
              d.fault = 1'b1;
            end
            d.open[b] = 1'b0;
            d.sp[b] = 4'h0;
          end
        end
      end
      sdtb_pkg::SDTB_BURST_END: begin
        stop = 1'b1;
      end
      sdtb_pkg::SDTB_READ, sdtb_pkg::SDTB_WRITE: begin
        if (too_soon(q.sa[bsel], `SDTB_T_RCD)) begin
          d.fault = 1'b1;
        end
        if (q.open[bsel]) begin
          // A new column command preempts any running burst
          stop = 1'b1;
          iss_v = 1'b1;
          iss_wr = (cmd == sdtb_pkg::SDTB_WRITE);
          iss_bank = bsel;
          iss_col = bus.addr[COL_W-1:0];
          iss_left = BW'(BURST_LEN);
          iss_ap = apin;
        end
      end
      default: begin
      end
    endcase
    if (q.bact && !stop) begin
      iss_v = 1'b1;
      iss_wr = q.bwr;
      iss_bank = q.bbank;
      iss_col = q.bcol;
      iss_left = q.bleft;
      iss_ap = q.bap;
    end
    if (stop || iss_v) begin
      d.bact = 1'b0;
    end
    idx = {iss_bank, q.row[iss_bank], iss_col};
    mw_en = iss_v && iss_wr;
    mw_be = ~bus.dqm;
    if (iss_v) begin
      if (!iss_wr) begin
        // Word leaves the output register two edges later
        d.p1v = 1'b1;
        d.p1d = mem[idx];
      end
      if (iss_left > BW'(1)) begin
        d.bact = 1'b1;
        d.bwr = iss_wr;
        d.bbank = iss_bank;
        d.bap = iss_ap;
        d.bcol = iss_col + COL_W'(1);
        d.bleft = iss_left - BW'(1);
      end else if (iss_ap) begin
        // Read closes two cycles before its last word leaves
        d.apc = iss_wr ? 3'(`SDTB_T_DPL) : 3'(`SDTB_CL - `SDTB_T_PQL);
        d.apb = iss_bank;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (mw_en) begin
      for (int b = 0; b < 2; b++) begin
        if (mw_be[b]) begin
          mem[idx][b*8 +: 8] <= bus.dq_ctl[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
      q.sa <= '1;
      q.sp <= '1;
      q.sx <= '1;
      q.sm <= '1;
    end else begin
      q <= d;
    end
  end

  assign bus.dq_dev = q.qd;
  assign bus.dq_dev_oe = q.qoe;
  assign mode_reg_out = q.mode;
  assign bank_open_out = q.open;
  assign burst_active_out = q.bact;
  assign refresh_busy_out = (q.refc != 4'h0);
  assign self_refresh_out = q.self;
  assign timing_fault_out = q.fault;
endmodule

// File: sdtb_ctl.sv
/*
  Memory controller end: power-up, close-all, mode load, periodic refresh,
  self-refresh on request, and single-word accesses as autoclose bursts.
  Assumes the device shares clk_sys_in; user requests use valid/ready.
*/
`timescale 1ns/1ps
`include "sdtb_params.svh"
module sdtb_ctl #(
  parameter int                      POWERUP_CYC = `SDTB_POWERUP_CYC,
  parameter int                      REF_INT_CYC = `SDTB_REF_INT_CYC,
  parameter int                      BURST_LEN   = `SDTB_BURST_LEN,
  parameter logic [`SDTB_ADDR_W-1:0] MODE_VALUE  = 12'h000
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   arst_n_in,
  sdtb_if.ctl                         bus,
  input  wire logic                   req_valid_in,
  output logic                        req_ready_out,
  input  wire logic                   req_write_in,
  input  wire logic                   req_bank_in,
  input  wire logic [`SDTB_ROW_W-1:0] req_row_in,
  input  wire logic [`SDTB_COL_W-1:0] req_col_in,
  input  wire logic [`SDTB_DQ_W-1:0]  req_wdata_in,
  output logic                        rsp_valid_out,
  output logic [`SDTB_DQ_W-1:0]       rsp_rdata_out,
  input  wire logic                   sleep_in,
  output logic                        init_done_out
);
  localparam int GAP_RD = BURST_LEN - 1 + (`SDTB_CL - `SDTB_T_PQL) + `SDTB_T_RP;
  localparam int GAP_WR = BURST_LEN - 1 + `SDTB_T_DAL;
  localparam int GAP_RC = `SDTB_T_RC - `SDTB_T_RCD;

  typedef struct packed {
    sdtb_pkg::sdtb_state_t   st;
    sdtb_pkg::sdtb_state_t   nxt;
    logic [15:0]             wcnt;
    logic [15:0]             rcnt;
    logic                    ref_due;
    logic                    cke;
    sdtb_pkg::sdtb_cmd_t     cmd;
    logic [`SDTB_ADDR_W-1:0] addr;
    logic [1:0]              dqm;
    logic [`SDTB_DQ_W-1:0]   dq;
    logic                    dqoe;
    logic                    wr;
    logic                    bank;
    logic [`SDTB_COL_W-1:0]  col;
    logic [`SDTB_DQ_W-1:0]   wdata;
    logic [2:0]              lat;
    logic [3:0]              bcnt;
    logic                    rsp_v;
    logic [`SDTB_DQ_W-1:0]   rsp_d;
    logic                    init;
  } sdtb_ctl_st_t;

  sdtb_ctl_st_t q;
  sdtb_ctl_st_t d;
  logic         tick;
  logic         taken;
  logic         woke;

  // Wait count so that the next command lands gap cycles after this one
  function automatic logic [15:0] wait_for(input int gap);
    return 16'(gap - 2);
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  assign req_ready_out = (q.st == sdtb_pkg::SDTB_S_IDLE) && !q.ref_due && !sleep_in;

  always_comb begin
    d = q;
    d.cmd = sdtb_pkg::SDTB_NOP;
    d.dqoe = 1'b0;
    d.dqm = 2'b00;
    d.rsp_v = 1'b0;
    tick = 1'b0;
    taken = 1'b0;
    woke = 1'b0;
    if (q.rcnt == 16'h0) begin
      tick = 1'b1;
      d.rcnt = 16'(REF_INT_CYC - 1);
    end else begin
      d.rcnt = q.rcnt - 16'h1;
    end
    if (q.lat != 3'h0) begin
      d.lat = q.lat - 3'h1;
      if (q.lat == 3'h1) begin
        d.rsp_v = 1'b1;
        d.rsp_d = bus.dq_dev;
      end
    end
    if (q.bcnt != 4'h0) begin
      d.bcnt = q.bcnt - 4'h1;
      d.dqm = 2'b11;
    end
    case (q.st)
      sdtb_pkg::SDTB_S_POWERUP: begin
        if (q.wcnt == 16'h0) begin
          d.st = sdtb_pkg::SDTB_S_CLOSEALL;
        end else begin
          d.wcnt = q.wcnt - 16'h1;
        end
      end
      sdtb_pkg::SDTB_S_CLOSEALL: begin
        d.cmd = sdtb_pkg::SDTB_CLOSE;
        d.addr = '0;
        d.addr[`SDTB_AP_BIT] = 1'b1;
        d.st = sdtb_pkg::SDTB_S_WAIT;
        d.nxt = sdtb_pkg::SDTB_S_MODE;
        d.wcnt = wait_for(`SDTB_T_RP);
      end
      sdtb_pkg::SDTB_S_MODE: begin
        d.cmd = sdtb_pkg::SDTB_MODE_LOAD;
        d.addr = MODE_VALUE;
        d.init = 1'b1;
        d.st = sdtb_pkg::SDTB_S_WAIT;
        d.nxt = sdtb_pkg::SDTB_S_IDLE;
        d.wcnt = wait_for(`SDTB_T_MCD);
      end
      sdtb_pkg::SDTB_S_IDLE: begin
        if (q.ref_due) begin
          taken = 1'b1;
          d.cmd = sdtb_pkg::SDTB_REFRESH;
          d.st = sdtb_pkg::SDTB_S_WAIT;
          d.nxt = sdtb_pkg::SDTB_S_IDLE;
          d.wcnt = wait_for(`SDTB_T_RC);
        end else if (sleep_in) begin
          d.cmd = sdtb_pkg::SDTB_REFRESH;
          d.cke = 1'b0;
          d.st = sdtb_pkg::SDTB_S_SELFREF;
        end else if (req_valid_in) begin
          d.cmd = sdtb_pkg::SDTB_OPEN;
          d.addr = {req_bank_in, req_row_in};
          d.wr = req_write_in;
          d.bank = req_bank_in;
          d.col = req_col_in;
          d.wdata = req_wdata_in;
          d.st = sdtb_pkg::SDTB_S_WAIT;
          d.nxt = sdtb_pkg::SDTB_S_COLUMN;
          d.wcnt = wait_for(`SDTB_T_RCD);
        end
      end
      sdtb_pkg::SDTB_S_COLUMN: begin
        d.cmd = q.wr ? sdtb_pkg::SDTB_WRITE : sdtb_pkg::SDTB_READ;
        d.addr = {q.bank, 1'b1, q.col};
        d.st = sdtb_pkg::SDTB_S_WAIT;
        d.nxt = sdtb_pkg::SDTB_S_IDLE;
        if (q.wr) begin
          d.dq = q.wdata;
          d.dqoe = 1'b1;
          d.bcnt = 4'(BURST_LEN - 1);
          d.wcnt = wait_for(max2(GAP_WR, GAP_RC));
        end else begin
          d.lat = 3'(`SDTB_CL + 1);
          d.wcnt = wait_for(max2(GAP_RD, GAP_RC));
        end
      end
      sdtb_pkg::SDTB_S_WAIT: begin
        if (q.wcnt == 16'h0) begin
          d.st = q.nxt;
        end else begin
          d.wcnt = q.wcnt - 16'h1;
        end
      end
      sdtb_pkg::SDTB_S_SELFREF: begin
        if (!sleep_in) begin
          woke = 1'b1;
          d.cke = 1'b1;
          d.st = sdtb_pkg::SDTB_S_WAIT;
          d.nxt = sdtb_pkg::SDTB_S_IDLE;
          d.wcnt = wait_for(`SDTB_T_RC);
        end
      end
      default: begin
        d.st = sdtb_pkg::SDTB_S_POWERUP;
      end
    endcase
    // A tick in the cycle the refresh is taken still stands
    d.ref_due = (q.ref_due && !taken) || tick || woke;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
      q.st <= sdtb_pkg::SDTB_S_POWERUP;
      q.nxt <= sdtb_pkg::SDTB_S_POWERUP;
      q.cmd <= sdtb_pkg::SDTB_NOP;
      q.cke <= 1'b1;
      q.wcnt <= 16'(POWERUP_CYC);
      q.rcnt <= 16'(REF_INT_CYC - 1);
    end else begin
      q <= d;
    end
  end

  assign bus.cke = q.cke;
  assign bus.cs_n = q.cmd[3];
  assign bus.ras_n = q.cmd[2];
  assign bus.cas_n = q.cmd[1];
  assign bus.we_n = q.cmd[0];
  assign bus.addr = q.addr;
  assign bus.dqm = q.dqm;
  assign bus.dq_ctl = q.dq;
  assign bus.dq_ctl_oe = q.dqoe;
  assign rsp_valid_out = q.rsp_v;
  assign rsp_rdata_out = q.rsp_d;
  assign init_done_out = q.init;
endmodule

// File: sdtb_link_monitor.sv
/*
  Assertions on the SDRAM link between controller and device.
  Assumes both ends share clk_sys_in and arst_n_in; fed the interface pins.
*/
`timescale 1ns/1ps
`include "sdtb_params.svh"
module sdtb_link_monitor (
  input wire logic       clk_sys_in,
  input wire logic       arst_n_in,
  input wire logic       cke,
  input wire logic       cs_n,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic [1:0] dqm,
  input wire logic       dq_ctl_oe,
  input wire logic [1:0] dq_dev_oe
);
  logic [3:0] cmd;
  logic       cke_q;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke;
    end
  end
  // A command counts only when clock enable was high at the previous edge
  wire is_cmd   = cke_q && !cs_n;
  wire quiet    = !is_cmd || (cmd == sdtb_pkg::SDTB_NOP);
  wire is_rd    = is_cmd && (cmd == sdtb_pkg::SDTB_READ);
  wire is_wr    = is_cmd && (cmd == sdtb_pkg::SDTB_WRITE);
  wire is_open  = is_cmd && (cmd == sdtb_pkg::SDTB_OPEN);
  wire is_close = is_cmd && (cmd == sdtb_pkg::SDTB_CLOSE);
  wire is_mode  = is_cmd && (cmd == sdtb_pkg::SDTB_MODE_LOAD);
  wire is_ref   = is_cmd && cke && (cmd == sdtb_pkg::SDTB_REFRESH);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_rd_open;
    is_rd ##1 (dqm == 2'b00);
  endsequence
  sequence s_quiet_ten;
    quiet [*8] ##1 quiet;
  endsequence
  a_read_latency: assert property (s_rd_open |-> ##2 (dq_dev_oe == 2'b11))
    else $error("read word not driven three cycles after read");
  a_open_to_col: assert property (is_open |=> (!is_rd && !is_wr) [*2])
    else $error("column command too soon after open");
  a_open_spacing: assert property (is_open |=> (!is_open) [*8] ##1 !is_open)
    else $error("open commands closer than ten cycles");
  a_open_to_close: assert property (is_open |=> (!is_close) [*5])
    else $error("close too soon after open");
  a_write_recovery: assert property (is_wr |=> (!is_open && !is_ref) [*7])
    else $error("open or refresh too soon after autoclose write");
  a_write_data: assert property (is_wr |-> dq_ctl_oe)
    else $error("write command without first data word");
  a_mask_read: assert property ((dqm == 2'b11) |-> ##2 (dq_dev_oe == 2'b00))
    else $error("masked read word still driven");
  a_mode_gap: assert property (is_mode |=> quiet)
    else $error("command too soon after mode load");
  a_refresh_quiet: assert property (is_ref |=> s_quiet_ten)
    else $error("command during refresh period");
endmodule

// File: tb_top.sv
/*
  Testbench joining controller and device through sdtb_if.
  Assumes a 100 MHz clock; power-up and refresh counts shortened.
*/
`timescale 1ns/1ps
`include "sdtb_params.svh"
module tb_top;
  logic                   clk_sys_in = 1'b0;
  logic                   arst_n_in = 1'b0;
  logic                   req_valid_in = 1'b0;
  logic                   req_write_in = 1'b0;
  logic                   req_bank_in = 1'b0;
  logic [`SDTB_ROW_W-1:0] req_row_in = '0;
  logic [`SDTB_COL_W-1:0] req_col_in = '0;
  logic [`SDTB_DQ_W-1:0]  req_wdata_in = '0;
  logic                   sleep_in = 1'b0;
  logic                   req_ready_out, rsp_valid_out, init_done_out;
  logic [`SDTB_DQ_W-1:0]  rsp_rdata_out;
  logic [11:0]            mode_reg_out;
  logic [1:0]             bank_open_out;
  logic                   refresh_busy_out, self_refresh_out, timing_fault_out, burst_active_out;
  int                     n_errors = 0;
  int                     compares = 0;
  logic [15:0]            rd;
  always #5 clk_sys_in = ~clk_sys_in;
  sdtb_if bus_if ();
  sdtb_dev i_sdtb_dev (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .bus(bus_if),
    .mode_reg_out(mode_reg_out), .bank_open_out(bank_open_out), .burst_active_out(burst_active_out),
    .refresh_busy_out(refresh_busy_out), .self_refresh_out(self_refresh_out),
    .timing_fault_out(timing_fault_out));
  sdtb_ctl #(.POWERUP_CYC(20), .REF_INT_CYC(200), .MODE_VALUE(12'h022)) i_sdtb_ctl (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .bus(bus_if), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_write_in(req_write_in), .req_bank_in(req_bank_in),
    .req_row_in(req_row_in), .req_col_in(req_col_in), .req_wdata_in(req_wdata_in),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .sleep_in(sleep_in),
    .init_done_out(init_done_out));
  sdtb_link_monitor i_sdtb_link_monitor (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .cke(bus_if.cke), .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n),
    .we_n(bus_if.we_n), .dqm(bus_if.dqm), .dq_ctl_oe(bus_if.dq_ctl_oe), .dq_dev_oe(bus_if.dq_dev_oe));
  task automatic complete_run();
    $display("Counts: %0d compares, %0d errors", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic probe(input int k);
    case (k)
      0: return req_ready_out;
      1: return rsp_valid_out;
      2: return init_done_out;
      3: return refresh_busy_out;
      default: return self_refresh_out;
    endcase
  endfunction
  // Bounded wait on a status level, sampled at each rising edge
  task automatic wait_for(input int k, input logic lvl, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_sys_in);
      if (probe(k) === lvl) return;
    end
    chk(32'h0, 32'h1);
    complete_run();
  endtask
  task automatic access(input logic w, input logic b, input logic [10:0] row, input logic [9:0] col,
                        input logic [15:0] wd);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_bank_in <= b;
    req_row_in <= row;
    req_col_in <= col;
    req_wdata_in <= wd;
    wait_for(0, 1'b1, 400);
    req_valid_in <= 1'b0;
    if (!w) begin
      wait_for(1, 1'b1, 20);
      rd = rsp_rdata_out;
    end else begin
      repeat (5) @(posedge clk_sys_in);
      chk(burst_active_out, 1'b1);
    end
  endtask
  task automatic t_rw();
    wait_for(2, 1'b1, 200);
    access(1'b1, 1'b0, 11'h000, 10'h005, 16'ha5c3);
    access(1'b1, 1'b1, 11'h7ff, 10'h3ff, 16'h5a3c);
    access(1'b1, 1'b0, 11'h000, 10'h004, 16'h0f1e);
    access(1'b0, 1'b0, 11'h000, 10'h005, 16'h0000);
    chk(rd, 16'ha5c3);
    repeat (2) @(posedge clk_sys_in);
    chk(bank_open_out, 2'b00);
    chk(burst_active_out, 1'b0);
    access(1'b0, 1'b0, 11'h000, 10'h004, 16'h0000);
    chk(rd, 16'h0f1e);
    access(1'b0, 1'b1, 11'h7ff, 10'h3ff, 16'h0000);
    chk(rd, 16'h5a3c);
    chk(mode_reg_out, 12'h022);
    $display("test rw done");
  endtask
  task automatic t_refresh();
    int n;
    wait_for(3, 1'b0, 50);
    wait_for(3, 1'b1, 400);
    chk(req_ready_out, 1'b0);
    for (n = 1; n < 40; n++) begin
      @(posedge clk_sys_in);
      if (refresh_busy_out !== 1'b1) break;
    end
    chk(n, 10);
    $display("test refresh done");
  endtask
  task automatic t_sleep();
    sleep_in <= 1'b1;
    wait_for(4, 1'b1, 400);
    chk(bus_if.cke, 1'b0);
    chk(req_ready_out, 1'b0);
    repeat (30) @(posedge clk_sys_in);
    chk(self_refresh_out, 1'b1);
    sleep_in <= 1'b0;
    wait_for(4, 1'b0, 50);
    wait_for(3, 1'b1, 50);
    access(1'b0, 1'b1, 11'h7ff, 10'h3ff, 16'h0000);
    chk(rd, 16'h5a3c);
    $display("test sleep done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    t_rw();
    t_refresh();
    t_sleep();
    chk(timing_fault_out, 1'b0);
    complete_run();
  end
endmodule
